// ===== src/teach_lock_ctrl.sv
`timescale 1ns/1ps
module teach_lock_ctrl (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic power_good,
   input wire logic actuator_present,
   input wire logic [31:0] actuator_code,
   input wire logic magnet_in,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic lock_engaged,
   output logic safety_output_a,
   output logic safety_output_b,
   output logic led_green,
   output logic led_red,
   output logic led_yellow,
   output logic irq
);
   teach_lock_pkg::teach_state_t state_q, state_d;
   teach_lock_pkg::avl_req_t req;
   teach_lock_pkg::led_t led_d;
   logic [31:0] ctrl_q;
   logic [teach_lock_pkg::IRQ_W-1:0] irq_stat_q, irq_mask_q, ev;
   logic [25:0] pre_q;
   logic tick;
   logic [2:0] phase_q;
   logic [15:0] tmr_q;
   logic tmr_clr;
   logic power_q, power_up, actuator_q, actuator_rise;
   logic [31:0] stored_code_q, learned_code_q;
   logic stored_valid_q, learned_pending_q, inhibit_pending_q, seen_new_q;
   logic [3:0] red_cnt_q;
   logic ack_q;
   logic acc_new;
   logic code_match;

   assign req = '{avs_address, avs_read, avs_write, avs_writedata};

   // six ticks a second give both the 1 Hz and 3 Hz patterns from one counter
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_q <= 26'h0000000;
      end else if (pre_q == 26'(teach_lock_pkg::TICK_DIV - 1)) begin
         pre_q <= 26'h0000000;
      end else begin
         pre_q <= pre_q + 26'h0000001;
      end
   end
   assign tick = (pre_q == 26'(teach_lock_pkg::TICK_DIV - 1));

   // flash phase, wraps every second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q <= 3'h0;
      end else if (tick) begin
         phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
      end
   end

   // state timer in ticks, cleared on each state change
   // saturates rather than wrapping, so a long stay never looks like a fresh state
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tmr_q <= 16'h0000;
      end else if (tmr_clr) begin
         tmr_q <= 16'h0000;
      end else if (tick && tmr_q != 16'hFFFF) begin
         tmr_q <= tmr_q + 16'h0001;
      end
   end
   assign tmr_clr = (state_d != state_q);

   // edge detect on supply and actuator sensing
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         power_q <= 1'b0;
         actuator_q <= 1'b0;
      end else begin
         power_q <= power_good;
         actuator_q <= actuator_present && power_good;
      end
   end
   assign power_up = power_good && !power_q;
   assign actuator_rise = actuator_present && power_good && !actuator_q;
   assign code_match = stored_valid_q && (actuator_code == stored_code_q);

   // teach sequencer; supply loss always returns to idle
   always_comb begin
      state_d = state_q;
      if (!power_good) begin
         state_d = teach_lock_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            teach_lock_pkg::ST_IDLE: begin
               // out of reset with supply already up
               if (power_q == 1'b1) begin
                  state_d = teach_lock_pkg::ST_RUN;
               end
               if (power_up) begin
                  if (learned_pending_q) begin
                     state_d = teach_lock_pkg::ST_CONFIRM;
                  end else if (inhibit_pending_q) begin
                     state_d = teach_lock_pkg::ST_INHIBIT;
                  end else begin
                     state_d = teach_lock_pkg::ST_RUN;
                  end
               end
            end
            teach_lock_pkg::ST_RUN: begin
               // teach only on an insertion within the first tick after entering run, as after a power cycle
               if (actuator_rise && !ctrl_q[teach_lock_pkg::CTRL_STD_CODING_BIT]
                   && !code_match && tmr_q == 16'h0000) begin
                  if (!(ctrl_q[teach_lock_pkg::CTRL_ONE_TIME_BIT] && stored_valid_q)) begin
                     state_d = teach_lock_pkg::ST_TEACH;
                  end
               end
            end
            teach_lock_pkg::ST_TEACH: begin
               if (tmr_q >= 16'(teach_lock_pkg::TEACH_FLASH_TICKS)) begin
                  state_d = teach_lock_pkg::ST_POWEROFF_REQ;
               end
            end
            teach_lock_pkg::ST_POWEROFF_REQ: begin
               if (tmr_q >= 16'(teach_lock_pkg::POWEROFF_TICKS)) begin
                  state_d = teach_lock_pkg::ST_ABORT;
               end
            end
            teach_lock_pkg::ST_ABORT: begin
               // back to normal use once all five flashes have been shown
               if (red_cnt_q == 4'(teach_lock_pkg::RED_FLASH_COUNT)) begin
                  state_d = teach_lock_pkg::ST_RUN;
               end
            end
            teach_lock_pkg::ST_CONFIRM: begin
               if (actuator_present && actuator_code == learned_code_q) begin
                  state_d = ctrl_q[teach_lock_pkg::CTRL_REPEAT_BIT]
                     ? teach_lock_pkg::ST_INHIBIT : teach_lock_pkg::ST_RUN;
               end
            end
            teach_lock_pkg::ST_INHIBIT: begin
               if (tmr_q >= 16'(teach_lock_pkg::INHIBIT_TICKS) && seen_new_q) begin
                  state_d = teach_lock_pkg::ST_RUN;
               end
            end
            default: state_d = teach_lock_pkg::ST_IDLE;
         endcase
      end
   end

   // sequencer state register
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= teach_lock_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // code storage; the pending flags model nonvolatile state across supply loss
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stored_code_q <= 32'h0000_0000;
         stored_valid_q <= 1'b0;
         learned_code_q <= 32'h0000_0000;
         learned_pending_q <= 1'b0;
         inhibit_pending_q <= 1'b0;
      end else begin
         // code captured during the first tick of teach-in
         if (state_q == teach_lock_pkg::ST_TEACH && tmr_q == 16'h0000) begin
            learned_code_q <= actuator_code;
         end
         // supply dropped as asked: keep the code for the confirm step
         if (state_q == teach_lock_pkg::ST_POWEROFF_REQ && !power_good) begin
            learned_pending_q <= 1'b1;
         end
         // abort forgets the half-learned code
         if (state_d == teach_lock_pkg::ST_ABORT) begin
            learned_pending_q <= 1'b0;
         end
         // new code replaces the old one at once; no window with both valid
         if (state_q == teach_lock_pkg::ST_CONFIRM && state_d != state_q && power_good) begin
            stored_code_q <= learned_code_q;
            stored_valid_q <= 1'b1;
            learned_pending_q <= 1'b0;
            inhibit_pending_q <= ctrl_q[teach_lock_pkg::CTRL_REPEAT_BIT];
         end
         // inhibit served, a later power cycle must not restart it
         if (state_q == teach_lock_pkg::ST_INHIBIT && state_d == teach_lock_pkg::ST_RUN) begin
            inhibit_pending_q <= 1'b0;
         end
      end
   end

   // new actuator must be seen during the inhibit; restart clears it too
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         seen_new_q <= 1'b0;
      end else if (state_q != teach_lock_pkg::ST_INHIBIT) begin
         seen_new_q <= 1'b0;
      end else if (actuator_present && code_match) begin
         seen_new_q <= 1'b1;
      end
   end

   // five red flashes, one per second
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         red_cnt_q <= 4'h0;
      end else if (state_q != teach_lock_pkg::ST_ABORT) begin
         red_cnt_q <= 4'h0;
      end else if (tick && phase_q == 3'h5) begin
         red_cnt_q <= red_cnt_q + 4'h1;
      end
   end

   // led patterns; 3 Hz short flash is one tick lit out of two
   always_comb begin
      led_d = '{1'b1, 1'b0, 1'b0};
      unique case (state_q)
         teach_lock_pkg::ST_IDLE: led_d = '{1'b0, 1'b0, 1'b0};
         teach_lock_pkg::ST_TEACH: led_d = '{1'b0, 1'b1, phase_q < 3'h3};
         teach_lock_pkg::ST_POWEROFF_REQ: led_d = '{1'b0, 1'b1, !phase_q[0]};
         teach_lock_pkg::ST_ABORT: led_d = '{1'b0, phase_q < 3'h3, 1'b0};
         teach_lock_pkg::ST_CONFIRM: led_d = '{1'b0, 1'b1, 1'b0};
         teach_lock_pkg::ST_INHIBIT: led_d = '{phase_q < 3'h3, 1'b0, 1'b0};
         teach_lock_pkg::ST_RUN: led_d = '{1'b1, 1'b0, lock_engaged};
         default: led_d = '{1'b0, 1'b0, 1'b0};
      endcase
   end

   // lock state and safety outputs; outputs off in every teach phase
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_engaged <= 1'b0;
         safety_output_a <= 1'b0;
         safety_output_b <= 1'b0;
         led_green <= 1'b0;
         led_red <= 1'b0;
         led_yellow <= 1'b0;
      end else begin
         lock_engaged <= power_good && (ctrl_q[teach_lock_pkg::CTRL_POWER_TO_LOCK_BIT]
            ? magnet_in : !magnet_in);
         safety_output_a <= (state_q == teach_lock_pkg::ST_RUN) && actuator_present
            && (ctrl_q[teach_lock_pkg::CTRL_STD_CODING_BIT] || code_match)
            && (lock_engaged || !ctrl_q[teach_lock_pkg::CTRL_LOCK_MON_BIT]);
         safety_output_b <= (state_q == teach_lock_pkg::ST_RUN) && actuator_present
            && (ctrl_q[teach_lock_pkg::CTRL_STD_CODING_BIT] || code_match)
            && (lock_engaged || !ctrl_q[teach_lock_pkg::CTRL_LOCK_MON_BIT]);
         led_green <= led_d.green;
         led_red <= led_d.red;
         led_yellow <= led_d.yellow;
      end
   end

   // events into the sticky status
   always_comb begin
      ev = '0;
      ev[teach_lock_pkg::IRQ_TEACH_START] = state_d == teach_lock_pkg::ST_TEACH && tmr_clr;
      ev[teach_lock_pkg::IRQ_POWEROFF_REQ] = state_d == teach_lock_pkg::ST_POWEROFF_REQ
         && tmr_clr;
      ev[teach_lock_pkg::IRQ_TEACH_ABORT] = state_d == teach_lock_pkg::ST_ABORT && tmr_clr;
      ev[teach_lock_pkg::IRQ_CODE_STORED] = state_q == teach_lock_pkg::ST_CONFIRM && tmr_clr
         && power_good;
      ev[teach_lock_pkg::IRQ_INHIBIT_DONE] = state_q == teach_lock_pkg::ST_INHIBIT
         && state_d == teach_lock_pkg::ST_RUN;
   end

   // one wait cycle per access keeps read data registered
   assign acc_new = (req.read || req.write) && !ack_q;
   assign avs_waitrequest = (req.read || req.write) && !ack_q;

   // ack marks the answer cycle; a request still held after it starts again the next cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= acc_new;
      end
   end

   // register writes take effect at the accepting edge; set beats clear
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= teach_lock_pkg::CTRL_RESET;
         irq_mask_q <= '0;
         irq_stat_q <= '0;
      end else begin
         // bits above the control field are dropped and read back as zero
         if (ack_q && req.write && req.address == teach_lock_pkg::CTRL_OFS) begin
            ctrl_q <= {27'h0000000, req.writedata[4:0]};
         end
         if (ack_q && req.write && req.address == teach_lock_pkg::IRQ_MASK_OFS) begin
            irq_mask_q <= req.writedata[teach_lock_pkg::IRQ_W-1:0];
         end
         if (ack_q && req.write && req.address == teach_lock_pkg::IRQ_STAT_OFS) begin
            irq_stat_q <= (irq_stat_q & ~req.writedata[teach_lock_pkg::IRQ_W-1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
      end
   end

   // read data registered during the wait cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (acc_new) begin
         // status packs the sequencer state with the live flags
         unique case (req.address)
            teach_lock_pkg::CTRL_OFS: avs_readdata <= ctrl_q;
            teach_lock_pkg::STATUS_OFS: avs_readdata <= {16'h0000, 2'h0, stored_valid_q,
               inhibit_pending_q, learned_pending_q, lock_engaged, safety_output_a,
               actuator_present, 1'b0, state_q};
            teach_lock_pkg::IRQ_STAT_OFS: avs_readdata <= {27'h0000000, irq_stat_q};
            teach_lock_pkg::IRQ_MASK_OFS: avs_readdata <= {27'h0000000, irq_mask_q};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // level interrupt, high while any unmasked status bit is set
   assign irq = |(irq_stat_q & irq_mask_q);
endmodule // teach_lock_ctrl

// ===== pkg/teach_lock_pkg.sv
package teach_lock_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned TICK_HZ = 6;
   localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
   localparam int unsigned TEACH_FLASH_S = 10;
   localparam int unsigned POWEROFF_WAIT_MIN = 5;
   localparam int unsigned INHIBIT_MIN = 10;
   localparam int unsigned SEC_PER_MIN = 60;
   localparam int unsigned TEACH_FLASH_TICKS = TEACH_FLASH_S * TICK_HZ;
   localparam int unsigned POWEROFF_TICKS = POWEROFF_WAIT_MIN * SEC_PER_MIN * TICK_HZ;
   localparam int unsigned INHIBIT_TICKS = INHIBIT_MIN * SEC_PER_MIN * TICK_HZ;
   localparam int unsigned RED_FLASH_COUNT = 5;

   // avalon register map, byte addresses
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
   localparam logic [3:0] IRQ_MASK_OFS = 4'hC;

   // control register fields
   localparam int unsigned CTRL_STD_CODING_BIT = 0;
   localparam int unsigned CTRL_ONE_TIME_BIT = 1;
   localparam int unsigned CTRL_REPEAT_BIT = 2;
   localparam int unsigned CTRL_POWER_TO_LOCK_BIT = 3;
   localparam int unsigned CTRL_LOCK_MON_BIT = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0015;

   // interrupt bits
   localparam int unsigned IRQ_TEACH_START = 0;
   localparam int unsigned IRQ_POWEROFF_REQ = 1;
   localparam int unsigned IRQ_TEACH_ABORT = 2;
   localparam int unsigned IRQ_CODE_STORED = 3;
   localparam int unsigned IRQ_INHIBIT_DONE = 4;
   localparam int unsigned IRQ_W = 5;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_TEACH = 7'h02,
      ST_POWEROFF_REQ = 7'h04,
      ST_ABORT = 7'h08,
      ST_CONFIRM = 7'h10,
      ST_INHIBIT = 7'h20,
      ST_RUN = 7'h40
   } teach_state_t;

   typedef struct packed {
      logic green;
      logic red;
      logic yellow;
   } led_t;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avl_req_t;
endpackage

// ===== test/actuator_supply_model.sv
`timescale 1ns/1ps
module actuator_supply_model (
   input wire logic core_clk,
   output logic power_good,
   output logic actuator_present,
   output logic [31:0] actuator_code,
   output logic magnet_in
);
   // supply up, nothing in range, magnet input at 0 V
   initial begin
      power_good = 1'b1;
      actuator_present = 1'b0;
      actuator_code = 32'h0;
      magnet_in = 1'b0;
   end
   // dropping and restoring supply is what opens a teach-in
   task automatic supply(input logic on);
      @(posedge core_clk);
      power_good <= on;
   endtask
   task automatic insert(input logic [31:0] code);
      @(posedge core_clk);
      actuator_code <= code;
      actuator_present <= 1'b1;
   endtask
   // a withdrawn actuator leaves no valid code, so the line shows junk
   task automatic withdraw();
      @(posedge core_clk);
      actuator_present <= 1'b0;
      actuator_code <= ~actuator_code;
   endtask
   task automatic set_magnet(input logic v);
      @(posedge core_clk);
      magnet_in <= v;
   endtask
endmodule // actuator_supply_model

// ===== test/teach_lock_ctrl_asserts.sv
`timescale 1ns/1ps
module teach_lock_ctrl_asserts (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic power_good,
   input wire logic actuator_present,
   input wire logic magnet_in,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic lock_engaged,
   input wire logic safety_output_a,
   input wire logic safety_output_b,
   input wire logic irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic [4:0] ctrl_q;
   logic [4:0] mask_q;
   logic [1:0] up_q;
   logic done_wr;
   logic lock_want;
   // completed write, and the lock level the magnet input asks for
   assign done_wr = avs_write & ~avs_waitrequest;
   assign lock_want = power_good & (ctrl_q[3] ? magnet_in : ~magnet_in);
   // shadow of control and mask, updated at the same edge as the design
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= 5'h15;
         mask_q <= 5'h00;
      end else if (done_wr && avs_address == teach_lock_pkg::CTRL_OFS) begin
         ctrl_q <= avs_writedata[4:0];
      end else if (done_wr && avs_address == teach_lock_pkg::IRQ_MASK_OFS) begin
         mask_q <= avs_writedata[4:0];
      end
   end
   // lock history is only trusted a few edges after reset
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) up_q <= 2'h0;
      else if (!(&up_q)) up_q <= up_q + 2'h1;
   end
   a_lock_input_map: assert property (&up_q |-> lock_engaged == $past(lock_want))
      else $error("lock does not follow magnet input");
   a_out_pair_equal: assert property (safety_output_a == safety_output_b)
      else $error("safety outputs disagree");
   a_out_need_actuator: assert property (safety_output_a |-> $past(actuator_present))
      else $error("safety output on without actuator");
   a_out_need_lock: assert property (
      safety_output_a && $past(ctrl_q[4]) |-> lock_engaged || $past(lock_engaged))
      else $error("safety output on while unlocked");
   a_wait_one_cycle: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not one cycle");
   a_ctrl_read_back: assert property (
      avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata == {27'h0, ctrl_q})
      else $error("control readback wrong");
   a_unmapped_zero: assert property (
      avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_needs_mask: assert property (irq |-> mask_q != 5'h00)
      else $error("interrupt with all sources masked");
   c_locked_out: cover property (safety_output_a && lock_engaged);
   c_irq: cover property (irq);
   c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0);
endmodule // teach_lock_ctrl_asserts
bind teach_lock_ctrl teach_lock_ctrl_asserts chk (.core_clk(core_clk), .reset_n(reset_n),
   .power_good(power_good), .actuator_present(actuator_present), .magnet_in(magnet_in),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .lock_engaged(lock_engaged),
   .safety_output_a(safety_output_a), .safety_output_b(safety_output_b), .irq(irq));

// ===== test/actuator_teach_and_lock_control_test.sv
`timescale 1ns/1ps
module actuator_teach_and_lock_control_test;
   logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest, lock_engaged, irq;
   logic power_good, actuator_present, magnet_in, safety_output_a, safety_output_b;
   logic led_green, led_red, led_yellow;
   logic [3:0] avs_address;
   logic [31:0] actuator_code, avs_writedata, avs_readdata, rd, rng;
   int mismatches, n_tests, ctrl_m, mask_m, stat_m;
   teach_lock_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .power_good(power_good),
      .actuator_present(actuator_present), .actuator_code(actuator_code), .magnet_in(magnet_in),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .lock_engaged(lock_engaged),
      .safety_output_a(safety_output_a), .safety_output_b(safety_output_b),
      .led_green(led_green), .led_red(led_red), .led_yellow(led_yellow), .irq(irq));
   actuator_supply_model partner (.core_clk(core_clk), .power_good(power_good),
      .actuator_present(actuator_present), .actuator_code(actuator_code), .magnet_in(magnet_in));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      #(20 * 5000);
      mismatches++;
      tally_and_finish();
   end
   function automatic logic [31:0] next_rand();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic lock_exp();
      return power_good & (ctrl_m[3] ? magnet_in : !magnet_in);
   endfunction
   // standard coding only: actuator, plus the lock when monitoring it
   function automatic logic safe_exp();
      return actuator_present & ctrl_m[0] & (!ctrl_m[4] | lock_exp());
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one avalon transfer, held until waitrequest is sampled low at a rising edge;
   // values read just after the edge are the ones the design sampled there
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) @(posedge core_clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (wr && a == teach_lock_pkg::CTRL_OFS) ctrl_m = d & 32'h1F;
      if (wr && a == teach_lock_pkg::IRQ_MASK_OFS) mask_m = d & 32'h1F;
      if (wr && a == teach_lock_pkg::IRQ_STAT_OFS) stat_m = stat_m & ~d;
      // let the write settle before the caller looks at outputs
      @(negedge core_clk);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      rng = 32'h0000004C;
      mismatches = 0;
      n_tests = 0;
      ctrl_m = 32'h15;
      mask_m = 0;
      stat_m = 0;
      reset_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      settle(2);
      // reset values, an unmapped place, bits above the control field
      bus(1'b0, teach_lock_pkg::CTRL_OFS, 32'h0);
      check("ctrl", rd, ctrl_m);
      bus(1'b0, teach_lock_pkg::STATUS_OFS, 32'h0);
      check("state", rd & 32'h7F, 32'h40);
      bus(1'b1, 4'h2, 32'hFFFFFFFF);
      bus(1'b0, 4'h2, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b1, teach_lock_pkg::CTRL_OFS, 32'hFFFFFFF1);
      bus(1'b0, teach_lock_pkg::CTRL_OFS, 32'h0);
      check("ctrl", rd, ctrl_m);
      $display("test registers done");
      // both magnet versions, both input levels, random supply drops
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, teach_lock_pkg::CTRL_OFS, {28'h0, i[2], 3'h1});
         rd = next_rand();
         partner.set_magnet(i[0]);
         partner.supply(rd[1] | i[1]);
         settle(3);
         check("lock", {31'h0, lock_engaged}, {31'h0, lock_exp()});
      end
      partner.supply(1'b1);
      $display("test lock done");
      // lock monitoring: unlock drops outputs, relock restores them
      bus(1'b1, teach_lock_pkg::CTRL_OFS, 32'h11);
      partner.insert(next_rand());
      for (int i = 0; i < 4; i++) begin
         if (i == 3) bus(1'b1, teach_lock_pkg::CTRL_OFS, 32'h01);
         partner.set_magnet(i[0]);
         settle(3);
         check("out a", {31'h0, safety_output_a}, {31'h0, safe_exp()});
         check("out b", {31'h0, safety_output_b}, {31'h0, safe_exp()});
      end
      partner.withdraw();
      settle(3);
      check("out a", {31'h0, safety_output_a}, 32'h0);
      $display("test outputs done");
      // coded unit: supply cycle, actuator arrives, teach-in starts
      partner.set_magnet(1'b0);
      bus(1'b1, teach_lock_pkg::CTRL_OFS, 32'h04);
      partner.supply(1'b0);
      settle(4);
      partner.supply(1'b1);
      settle(3);
      partner.insert(next_rand());
      settle(4);
      stat_m = 1 << teach_lock_pkg::IRQ_TEACH_START;
      bus(1'b0, teach_lock_pkg::STATUS_OFS, 32'h0);
      check("state", rd & 32'h7F, 32'h02);
      // the run ends well inside the first lit half-second of the yellow flash
      check("leds", {28'h0, led_green, led_red, led_yellow, safety_output_a}, 32'h6);
      check("irq", {31'h0, irq}, 32'h0);
      bus(1'b0, teach_lock_pkg::IRQ_STAT_OFS, 32'h0);
      check("irq stat", rd, stat_m);
      bus(1'b1, teach_lock_pkg::IRQ_MASK_OFS, stat_m);
      check("irq", {31'h0, irq}, {31'h0, (stat_m & mask_m) != 0});
      bus(1'b1, teach_lock_pkg::IRQ_STAT_OFS, stat_m);
      check("irq", {31'h0, irq}, {31'h0, (stat_m & mask_m) != 0});
      bus(1'b0, teach_lock_pkg::IRQ_STAT_OFS, 32'h0);
      check("irq stat", rd, stat_m);
      $display("test teach start done");
      tally_and_finish();
   end
endmodule // actuator_teach_and_lock_control_test
